// [ltotp_i2c_host.sv]
// Behavioural I2C bus master that drives the trim block's serial port
`timescale 1ns/1ps
module ltotp_i2c_host (
  // Clock and wire level
  input wire logic clock,
  input wire logic sda_wire,
  // Driven lines, 1 means released to the pull-up
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // SCL period of 8 clocks; SDA changes mid-low, sampled mid-high
  task automatic put_bit(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_wire;
    tick(2);
  endtask
  task automatic start();
    scl <= 1'b0;
    tick(2);
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    scl <= 1'b0;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // MSB first, then a released ack slot; nak is the level seen there
  task automatic put_byte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, nak);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] reg_a, input logic [7:0] d,
                           output logic nak);
    logic n0, n1, n2;
    start();
    put_byte({dev, 1'b0}, n0);
    put_byte(reg_a, n1);
    put_byte(d, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  // Register select by a write, then repeated start and one byte with NACK
  task automatic read_reg(input logic [7:0] reg_a, output logic [7:0] d);
    logic n, r;
    start();
    put_byte({7'h28, 1'b0}, n);
    put_byte(reg_a, n);
    start();
    put_byte({7'h28, 1'b1}, n);
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(1'b1, r);
    stop();
  endtask
endmodule

// [ltotp_osc_timer.sv]
// Gated fuse oscillator and fuse read cycle timer
`timescale 1ns/1ps
module ltotp_osc_timer
  import ltotp_pkg::*;
#(
  parameter int DIV = FUSE_OSC_DIV,
  parameter int TICKS = FUSE_READ_OSC_TICKS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [7:0] div_count;
  logic [7:0] tick_count;
  wire osc_tick = busy && (div_count == 8'(DIV - 1));
  wire last_tick = osc_tick && (tick_count == 8'(TICKS - 1));

  // Oscillator only runs while a read cycle is active
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      div_count <= 8'h00;
      tick_count <= 8'h00;
    end else begin
      done <= last_tick;
      if (start && !busy) begin
        busy <= 1'b1;
        div_count <= 8'h00;
        tick_count <= 8'h00;
      end else if (busy) begin
        div_count <= osc_tick ? 8'h00 : div_count + 8'h01;
        if (osc_tick) begin
          tick_count <= tick_count + 8'h01;
        end
        if (last_tick) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule

// [ltotp_pkg.sv]
// Package: register map, fuse timing and carrier types for the LED trim block
package ltotp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h28;
  localparam logic [7:0] ADDR_BUCK_TRIM = 8'h01;
  localparam logic [7:0] ADDR_LINEAR_TRIM = 8'h02;
  localparam logic [7:0] ADDR_FUSE_CTRL = 8'hff;
  localparam logic [5:0] BUCK_TRIM_RESET = 6'h1f;
  localparam logic [3:0] LINEAR_TRIM_RESET = 4'h7;
  localparam logic [7:0] FUSE_CTRL_RESET = 8'h08;
  localparam int FUSE_BURNED_BIT = 4;
  localparam int FUSE_PROGRAM_BIT = 2;
  localparam int FUSE_RELOAD_BIT = 0;
  // ----------------------------------------
  // Fuse read timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 100_000_000;
  localparam int FUSE_OSC_HZ = 500_000;
  localparam int FUSE_OSC_DIV = CLOCK_HZ / FUSE_OSC_HZ;
  localparam int FUSE_READ_US = 50;
  localparam int FUSE_READ_OSC_TICKS = FUSE_READ_US * FUSE_OSC_HZ / 1_000_000;
  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic burned;
    logic [3:0] linear_trim_code;
    logic [5:0] buck_trim_code;
  } ltotp_fuse_s;
  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } ltotp_pins_s;
endpackage

// [ltotp_trim.sv]
// I2C slave register block with fuse-backed LED current trims
`timescale 1ns/1ps
// Summary of operation
// - Buck trim six bits at 0x01
// - Buck code scales string current 0.625 percent steps
// - Linear trim four bits at 0x02, default 7
// - Linear code scales current 3.125 percent steps
// - Power-up copies fuses into both trims
// - Power-on load after enable with undervoltage lockout released, about 50 us
// - Fuse control resets 0x08, top bits zero
// - Burned flag updates only on fuse read
// - Program bit raises fuse supply to 8 V
// - Both trims burned together in one sequence
// - Reload bit starts fuse read, self clearing
// - Fuse oscillator enabled only during read
// - All fuse registers load at once
// - Slave address 0x28, register then data
// - Write takes effect at final ack edge
module ltotp_trim
  import ltotp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Power-on qualifiers
  input wire logic enable_ok,
  input wire logic undervoltage_lockout,
  // I2C pins
  input wire ltotp_pkg::ltotp_pins_s pins,
  output logic sda_out,
  output logic sda_oe,
  // Fuse array
  input wire ltotp_pkg::ltotp_fuse_s fuse_data,
  output logic fuse_burn,
  output logic fuse_supply_rail,
  // Analog trims and status
  output logic [5:0] buck_trim_code,
  output logic [3:0] linear_trim_code,
  output logic fuse_osc_enable
);
  typedef enum logic [2:0] {
    LT_IDLE, LT_ADDR, LT_REG, LT_WDATA, LT_RDATA, LT_IGNORE
  } ltotp_state_e;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [1:0] scl_sync, sda_sync;
  logic [1:0] enable_sync, lockout_sync;
  logic scl_prev, sda_prev;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      enable_sync <= 2'b00;
      lockout_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], pins.scl_in};
      sda_sync <= {sda_sync[0], pins.sda_in};
      // Enable and lockout come from analog comparators, so they are synchronised too
      enable_sync <= {enable_sync[0], enable_ok};
      lockout_sync <= {lockout_sync[0], undervoltage_lockout};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl && !scl_prev;
  wire scl_fall = !scl && scl_prev;
  wire start_cond = scl && scl_prev && sda_prev && !sda;
  wire stop_cond = scl && scl_prev && !sda_prev && sda;

  // ----------------------------------------
  // Registers and fuse cycle
  // ----------------------------------------
  ltotp_state_e state;
  logic [3:0] bit_count;
  logic [7:0] shift, reg_addr, tx_byte;
  logic ack_phase;
  ltotp_state_e ack_next;
  logic burned, fuse_start, powered, fuse_busy, fuse_done;

  wire power_ok = enable_sync[1] && !lockout_sync[1];
  // Ack slot opens on the fall after bit 8 and closes on the next fall
  wire byte_end = scl_fall && (bit_count == 4'h8) && !ack_phase;
  wire ack_end = scl_fall && ack_phase;
  wire tx_shift = scl_fall && (state == LT_RDATA) && !ack_phase
    && (bit_count != 4'h0) && (bit_count != 4'h8);
  wire addr_match = (shift[7:1] == SLAVE_ADDR);
  wire ack_drive = (state == LT_ADDR && addr_match) || state == LT_REG
    || state == LT_WDATA;
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire ack_rise = ack_phase && scl_rise;
  // Register write lands on the rising edge of the data-byte ack
  wire write_commit = ack_rise && (state == LT_WDATA);
  wire write_buck = write_commit && (reg_addr == ADDR_BUCK_TRIM) && !fuse_busy
    && !fuse_done;
  wire write_linear = write_commit && (reg_addr == ADDR_LINEAR_TRIM) && !fuse_busy
    && !fuse_done;
  wire write_fuse = write_commit && (reg_addr == ADDR_FUSE_CTRL);
  wire reload_req = write_fuse && shift[FUSE_RELOAD_BIT];
  wire [7:0] fuse_ctrl_read = {3'b000, burned, 1'b1, fuse_burn, 2'b00};
  wire [7:0] read_value =
    (reg_addr == ADDR_BUCK_TRIM) ? {2'b00, buck_trim_code} :
    (reg_addr == ADDR_LINEAR_TRIM) ? {4'h0, linear_trim_code} :
    (reg_addr == ADDR_FUSE_CTRL) ? fuse_ctrl_read : 8'h00;

  ltotp_osc_timer i_ltotp_osc_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(fuse_start),
    .busy(fuse_busy),
    .done(fuse_done)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      powered <= 1'b0;
      fuse_start <= 1'b0;
      fuse_osc_enable <= 1'b0;
    end else begin
      fuse_start <= (power_ok && !powered) || reload_req;
      fuse_osc_enable <= fuse_busy || fuse_start;
      if (power_ok) begin
        powered <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      buck_trim_code <= BUCK_TRIM_RESET;
      linear_trim_code <= LINEAR_TRIM_RESET;
      burned <= FUSE_CTRL_RESET[FUSE_BURNED_BIT];
      fuse_burn <= FUSE_CTRL_RESET[FUSE_PROGRAM_BIT];
      fuse_supply_rail <= 1'b0;
    end else begin
      // Every fuse-backed field loads on the same edge
      if (fuse_done) begin
        buck_trim_code <= fuse_data.buck_trim_code;
        linear_trim_code <= fuse_data.linear_trim_code;
        burned <= fuse_data.burned;
      end else begin
        if (write_buck) begin
          buck_trim_code <= shift[5:0];
        end
        if (write_linear) begin
          linear_trim_code <= shift[3:0];
        end
      end
      // Burn strobe covers both trims; host times the 25 ms hold
      if (write_fuse) begin
        fuse_burn <= shift[FUSE_PROGRAM_BIT];
        fuse_supply_rail <= shift[FUSE_PROGRAM_BIT];
      end
    end
  end

  // ----------------------------------------
  // I2C slave engine
  // ----------------------------------------
  // State moves to ack_next only when the ack slot closes, so a commit sees the byte being acked
  always_comb begin
    ack_next = LT_IGNORE;
    unique case (state)
      LT_ADDR: ack_next = !addr_match ? LT_IGNORE : (shift[0] ? LT_RDATA : LT_REG);
      LT_REG: ack_next = LT_WDATA;
      LT_RDATA: ack_next = LT_RDATA;
      default: ack_next = LT_IGNORE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= LT_IDLE;
      bit_count <= 4'd0;
      shift <= 8'h00;
      reg_addr <= 8'h00;
      tx_byte <= 8'h00;
      ack_phase <= 1'b0;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      // A repeated start keeps the selected register for a read
      state <= LT_ADDR;
      bit_count <= 4'd0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= LT_IDLE;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (state != LT_IDLE && state != LT_IGNORE) begin
      if (scl_rise && !ack_phase && bit_count < 4'd8) begin
        shift <= rx_byte;
        bit_count <= bit_count + 4'd1;
      end
      if (ack_rise) begin
        bit_count <= 4'h0;
      end
      if (ack_rise && state == LT_RDATA && sda) begin
        // Master NACK ends the read
        state <= LT_IGNORE;
      end
      if (byte_end) begin
        ack_phase <= 1'b1;
        sda_out <= 1'b0;
        sda_oe <= ack_drive;
      end else if (ack_end) begin
        // Release after the ack, or put out the first bit of a read byte
        ack_phase <= 1'b0;
        state <= ack_next;
        if (state == LT_REG) begin
          reg_addr <= shift;
        end
        if (ack_next == LT_RDATA) begin
          // Master ACK repeats the same register, there is no auto-increment
          sda_out <= read_value[7];
          sda_oe <= !read_value[7];
          tx_byte <= {read_value[6:0], 1'b0};
        end else begin
          sda_out <= 1'b1;
          sda_oe <= 1'b0;
        end
      end else if (tx_shift) begin
        sda_out <= tx_byte[7];
        sda_oe <= !tx_byte[7];
        tx_byte <= {tx_byte[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reset_value_a: assert property (@(posedge clock) $rose(reset_n) |->
    fuse_ctrl_read == FUSE_CTRL_RESET && linear_trim_code == LINEAR_TRIM_RESET)
    else $error("fuse control or linear trim reset value wrong");
  fuse_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    fuse_done |=> buck_trim_code == $past(fuse_data.buck_trim_code)
      && linear_trim_code == $past(fuse_data.linear_trim_code))
    else $error("fuse load did not update both trims");
  rail_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
    fuse_supply_rail == fuse_burn)
    else $error("fuse supply rail does not follow program bit");
  reload_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
    reload_req |=> ##[1:2] fuse_busy)
    else $error("reload did not start fuse read");
  osc_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    fuse_done |-> ##2 !fuse_osc_enable || fuse_start)
    else $error("oscillator left running after read");
  burned_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !$past(fuse_done) |-> $stable(burned))
    else $error("burned flag changed outside fuse read");
  fuse_priority_a: assert property (@(posedge clock) disable iff (!reset_n)
    fuse_busy && !fuse_done |=> $stable(buck_trim_code) && $stable(linear_trim_code))
    else $error("host write overrode fuse load");
  unmapped_a: assert property (@(posedge clock) disable iff (!reset_n)
    reg_addr != ADDR_BUCK_TRIM && reg_addr != ADDR_LINEAR_TRIM
      && reg_addr != ADDR_FUSE_CTRL |-> read_value == 8'h00)
    else $error("unmapped register not zero");
  commit_edge_a: assert property (@(posedge clock) disable iff (!reset_n)
    write_buck |=> buck_trim_code == $past(shift[5:0]))
    else $error("buck trim not written at ack edge");
endmodule

// [ltotp_trim_tb.sv]
// Self-checking bench for the fuse-backed LED trim register block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module ltotp_trim_tb;
  import ltotp_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, enable_ok = 1'b0, undervoltage_lockout = 1'b1;
  logic scl, sda_drv, sda_out, sda_oe, fuse_burn, fuse_supply_rail, fuse_osc_enable, nak;
  logic [5:0] buck_trim_code;
  logic [3:0] linear_trim_code;
  logic [7:0] rd;
  ltotp_fuse_s fuse_data = '0;
  ltotp_pins_s pins;
  int num_errors = 0, n_compared = 0, cycles = 0, n;
  // Open-drain wire with pull-up; low when the host drive or the block's enabled data output is low
  wire sda_wire = (sda_oe ? sda_out : 1'b1) & sda_drv;
  assign pins = {scl, sda_wire};
  always #5 clock = ~clock;
  ltotp_i2c_host host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  ltotp_trim i_ltotp_trim (.clock(clock), .reset_n(reset_n), .enable_ok(enable_ok),
    .undervoltage_lockout(undervoltage_lockout), .pins(pins), .sda_out(sda_out),
    .sda_oe(sda_oe), .fuse_data(fuse_data), .fuse_burn(fuse_burn),
    .fuse_supply_rail(fuse_supply_rail), .buck_trim_code(buck_trim_code),
    .linear_trim_code(linear_trim_code), .fuse_osc_enable(fuse_osc_enable));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for the oscillator enable to reach a level
  task automatic wait_osc(input logic lvl, input int lim);
    n = 0;
    while (fuse_osc_enable !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic t_reset_values();
    `CHK(buck_trim_code, 6'h1f)
    `CHK(linear_trim_code, 4'h7)
    host.read_reg(8'hff, rd);
    `CHK(rd, 8'h08)
    host.read_reg(8'h03, rd);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_power_load();
    fuse_data <= '{burned: 1'b0, linear_trim_code: 4'ha, buck_trim_code: 6'h2a};
    enable_ok <= 1'b1;
    host.tick(20);
    `CHK(fuse_osc_enable, 1'b0)
    undervoltage_lockout <= 1'b0;
    wait_osc(1'b1, 20);
    `CHK(fuse_osc_enable, 1'b1)
    `CHK(buck_trim_code, 6'h1f)
    wait_osc(1'b0, 6000);
    `CHK(n / 100, 50)
    `CHK(buck_trim_code, 6'h2a)
    `CHK(linear_trim_code, 4'ha)
  endtask
  task automatic t_reg_access();
    host.write_reg(7'h28, 8'h01, 8'hff, nak);
    `CHK(nak, 1'b0)
    `CHK(buck_trim_code, 6'h3f)
    host.read_reg(8'h01, rd);
    `CHK(rd, 8'h3f)
    host.write_reg(7'h28, 8'h02, 8'hff, nak);
    `CHK(linear_trim_code, 4'hf)
    host.read_reg(8'h02, rd);
    `CHK(rd, 8'h0f)
    host.write_reg(7'h28, 8'h05, 8'h5a, nak);
    host.read_reg(8'h05, rd);
    `CHK(rd, 8'h00)
    host.write_reg(7'h29, 8'h01, 8'h00, nak);
    `CHK(nak, 1'b1)
    `CHK(buck_trim_code, 6'h3f)
  endtask
  task automatic t_program();
    host.write_reg(7'h28, 8'h01, 8'h15, nak);
    host.write_reg(7'h28, 8'h02, 8'h03, nak);
    fuse_data <= '{burned: 1'b1, linear_trim_code: 4'h3, buck_trim_code: 6'h15};
    host.write_reg(7'h28, 8'hff, 8'h04, nak);
    `CHK({fuse_burn, fuse_supply_rail}, 2'b11)
    host.read_reg(8'hff, rd);
    `CHK(rd, 8'h0c)
    // Burn hold cut far below 25 ms to keep the run short
    host.tick(100);
    host.write_reg(7'h28, 8'hff, 8'h00, nak);
    `CHK({fuse_burn, fuse_supply_rail}, 2'b00)
  endtask
  task automatic t_reload();
    host.write_reg(7'h28, 8'h01, 8'h00, nak);
    `CHK(buck_trim_code, 6'h00)
    host.write_reg(7'h28, 8'hff, 8'h01, nak);
    `CHK(fuse_osc_enable, 1'b1)
    host.write_reg(7'h28, 8'h01, 8'h3f, nak);
    wait_osc(1'b0, 6000);
    `CHK(fuse_osc_enable, 1'b0)
    `CHK(buck_trim_code, 6'h15)
    `CHK(linear_trim_code, 4'h3)
    host.read_reg(8'hff, rd);
    `CHK(rd, 8'h18)
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    host.tick(3);
    t_reset_values();
    t_power_load();
    t_reg_access();
    t_program();
    t_reload();
    end_of_test();
  end
endmodule
